// ---- rtl/fcp_pkg.sv ----
/*
 Constants, command codes, status bit positions and read modes for the flash command and write-protect block.
 Assumes a single 125 MHz clock domain.
*/
package fcp_pkg;
	localparam logic [7:0] FCP_CMD_READ_ARRAY  = 8'hff;
	localparam logic [7:0] FCP_CMD_READ_ID     = 8'h90;
	localparam logic [7:0] FCP_CMD_READ_STATUS = 8'h70;
	localparam logic [7:0] FCP_CMD_CLEAR_STAT  = 8'h50;
	localparam logic [7:0] FCP_CMD_ERASE_SETUP = 8'h20;
	localparam logic [7:0] FCP_CMD_CONFIRM     = 8'hd0;
	localparam logic [7:0] FCP_CMD_PROG_SETUP  = 8'h40;
	localparam logic [7:0] FCP_CMD_PROG_ALT    = 8'h10;
	localparam logic [7:0] FCP_CMD_SUSPEND     = 8'hb0;

	localparam int FCP_SR_READY     = 7;
	localparam int FCP_SR_ERASE_SUS = 6;
	localparam int FCP_SR_ERASE_ERR = 5;
	localparam int FCP_SR_PROG_ERR  = 4;
	localparam int FCP_SR_SUPPLY    = 3;
	localparam int FCP_SR_PROG_SUS  = 2;
	localparam int FCP_SR_PROTECT   = 1;

	// Default duration of one array operation, in ns
	localparam int FCP_OP_TIME_NS  = 800;
	localparam int FCP_CLK_NS      = 8;
	localparam int FCP_OP_CYCLES   = FCP_OP_TIME_NS / FCP_CLK_NS;
	localparam logic [7:0] FCP_ERASED_BYTE = 8'hff;
	// Arbitrary identifier values
	localparam logic [7:0] FCP_ID_MAKER  = 8'h5a;
	localparam logic [7:0] FCP_ID_DEVICE = 8'h3c;

	typedef enum logic [1:0] {FCP_RD_ARRAY, FCP_RD_ID, FCP_RD_STATUS} fcp_rdmode_t;
endpackage : fcp_pkg

// ---- rtl/fcp_array_if.sv ----
/*
 Carrier between the command sequencer and the array operation timer.
 Assumes both ends share clk.
*/
interface fcp_array_if;
	logic start;
	logic pause;
	logic done;
	logic busy;
	modport seq (output start, output pause, input done, input busy);
	modport tmr (input start, input pause, output done, output busy);
endinterface : fcp_array_if

// ---- rtl/fcp_op_timer.sv ----
/*
 Counts out the duration of one program or erase; holds while paused.
 Assumes start only while idle.
*/
module fcp_op_timer
	import fcp_pkg::*;
#(
	parameter int OP_CYCLES = FCP_OP_CYCLES
)
(
	input  wire logic clk,
	input  wire logic reset,
	fcp_array_if.tmr  arr
);
	typedef struct packed {
		logic        busy;
		logic        done;
		logic [15:0] cnt;
	} fcp_tmr_t;
	fcp_tmr_t s_q, s_d;

	always_comb
	begin
		s_d = s_q;
		s_d.done = 1'b0;
		if (arr.start)
		begin
			s_d.busy = 1'b1;
			s_d.cnt  = 16'(OP_CYCLES);
		end
		else if (s_q.busy && !arr.pause)
		begin
			if (s_q.cnt <= 16'h0001)
			begin
				s_d.busy = 1'b0;
				s_d.done = 1'b1;
			end
			s_d.cnt = s_q.cnt - 16'h0001;
		end
	end

	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
			s_q <= '0;
		else
			s_q <= s_d;
	end

	assign arr.busy = s_q.busy;
	assign arr.done = s_q.done;
endmodule : fcp_op_timer

// ---- rtl/fcp_flash_command_protect.sv ----
/*
 Command decoder, write-state control, status register and hardware
 write protection for a small byte-wide flash array held in flip-flops.
 Assumes one host command write or read per cycle, on the same clock;
 the protect pins and supply monitor come from outside and are synchronised.
*/
module fcp_flash_command_protect
	import fcp_pkg::*;
#(
	parameter int BLOCKS      = 4,
	parameter int BLOCK_BYTES = 4,
	parameter int OP_CYCLES   = FCP_OP_CYCLES
)
(
	input  wire logic                                   clk,
	input  wire logic                                   reset,
	input  wire logic                                   cmd_write,
	input  wire logic [$clog2(BLOCKS*BLOCK_BYTES)-1:0]  cmd_addr,
	input  wire logic [7:0]                             cmd_data,
	input  wire logic                                   cmd_read,
	output logic      [7:0]                             read_data,
	input  wire logic                                   lock_write,
	input  wire logic [$clog2(BLOCKS)-1:0]              lock_block,
	input  wire logic                                   lock_wr_bit,
	input  wire logic                                   lock_rd_bit,
	output logic      [BLOCKS-1:0]                      write_lock_state,
	input  wire logic                                   top_block_lock_pin_n,
	input  wire logic                                   write_protect_pin_n,
	input  wire logic                                   supply_lockout_level,
	output logic                                        ready_flag
);
	localparam int AW = $clog2(BLOCKS*BLOCK_BYTES);
	localparam int BW = $clog2(BLOCKS);
	localparam int OW = $clog2(BLOCK_BYTES);
	localparam int DEPTH = BLOCKS*BLOCK_BYTES;
	localparam logic [BW-1:0] TOP_BLOCK = BW'(BLOCKS-1);

	typedef enum logic [2:0] {ST_IDLE, ST_ERASE_SETUP, ST_PROG_SETUP, ST_RUN, ST_SUSPEND} fcp_state_t;

	typedef struct packed {
		fcp_state_t        st;
		fcp_rdmode_t       rdmode;
		logic [7:0]        status;
		logic              op_erase;
		logic [AW-1:0]     op_addr;
		logic [7:0]        op_data;
		logic              pin_top_lk;
		logic              pin_rest_lk;
		logic [BLOCKS-1:0] wlock;
		logic [BLOCKS-1:0] rlock;
		logic [1:0]        tbl_sync;
		logic [1:0]        wp_sync;
		logic [1:0]        vpp_sync;
		logic [7:0]        rdata;
		logic [DEPTH-1:0][7:0] mem;
	} fcp_top_t;
	fcp_top_t s_q, s_d;

	fcp_array_if arr ();
	logic start_op;
	logic pause_op;
	assign arr.start = start_op;
	assign arr.pause = pause_op;

	fcp_op_timer #(.OP_CYCLES(OP_CYCLES)) u_timer (
		.clk   (clk),
		.reset (reset),
		.arr   (arr)
	);

	////////////////////////////////////////////////////////////////////////
	// Protection decision for a target block
	function automatic logic fcp_blocked(input logic [BW-1:0] blk, input fcp_top_t s, input logic top_lk,
		input logic rest_lk);
		logic pin_hit;
		pin_hit = (blk == TOP_BLOCK) ? top_lk : rest_lk;
		return pin_hit | s.wlock[blk];
	endfunction : fcp_blocked

	logic [BW-1:0] cmd_blk;
	logic [BW-1:0] op_blk;
	logic          pin_top_now;
	logic          pin_rest_now;
	logic          supply_low;
	assign cmd_blk = cmd_addr[AW-1:OW];
	assign op_blk  = s_q.op_addr[AW-1:OW];
	assign pin_top_now  = !s_q.tbl_sync[1];
	assign pin_rest_now = !s_q.wp_sync[1];
	assign supply_low   = s_q.vpp_sync[1];

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_comb
	begin
		logic go;
		logic fail_lock;
		go        = 1'b0;
		fail_lock = 1'b0;
		s_d       = s_q;
		start_op  = 1'b0;
		pause_op  = (s_q.st == ST_SUSPEND);
		s_d.tbl_sync = {s_q.tbl_sync[0], top_block_lock_pin_n};
		s_d.wp_sync  = {s_q.wp_sync[0], write_protect_pin_n};
		s_d.vpp_sync = {s_q.vpp_sync[0], supply_lockout_level};

		if (lock_write)
		begin
			s_d.wlock[lock_block] = lock_wr_bit;
			s_d.rlock[lock_block] = lock_rd_bit;
		end

		if (cmd_write)
		begin
			unique case (s_q.st)
				ST_IDLE:
				begin
					if (cmd_data == FCP_CMD_READ_ARRAY)
						s_d.rdmode = FCP_RD_ARRAY;
					else if (cmd_data == FCP_CMD_READ_ID)
						s_d.rdmode = FCP_RD_ID;
					else if (cmd_data == FCP_CMD_READ_STATUS)
						s_d.rdmode = FCP_RD_STATUS;
					else if (cmd_data == FCP_CMD_CLEAR_STAT)
						s_d.status[5:1] = 5'h00;
					else if (cmd_data == FCP_CMD_ERASE_SETUP)
					begin
						s_d.st      = ST_ERASE_SETUP;
						s_d.op_addr = cmd_addr;
						s_d.rdmode  = FCP_RD_STATUS;
					end
					else if (cmd_data == FCP_CMD_PROG_SETUP || cmd_data == FCP_CMD_PROG_ALT)
					begin
						s_d.st     = ST_PROG_SETUP;
						s_d.rdmode = FCP_RD_STATUS;
					end
				end
				ST_ERASE_SETUP:
				begin
					s_d.st = ST_IDLE;
					if (cmd_data == FCP_CMD_CONFIRM && cmd_blk == op_blk)
					begin
						go = 1'b1;
						s_d.op_erase = 1'b1;
					end
					else
					begin
						s_d.status[FCP_SR_ERASE_ERR] = 1'b1;
						s_d.status[FCP_SR_PROG_ERR]  = 1'b1;
					end
				end
				ST_PROG_SETUP:
				begin
					s_d.st       = ST_IDLE;
					go           = 1'b1;
					s_d.op_erase = 1'b0;
					s_d.op_addr  = cmd_addr;
					s_d.op_data  = cmd_data;
				end
				ST_RUN:
				begin
					if (cmd_data == FCP_CMD_SUSPEND)
						s_d.st = ST_SUSPEND;
				end
				ST_SUSPEND:
				begin
					if (cmd_data == FCP_CMD_CONFIRM)
					begin
						s_d.st     = ST_RUN;
						s_d.rdmode = FCP_RD_STATUS;
					end
					else if (cmd_data == FCP_CMD_READ_ARRAY)
						s_d.rdmode = FCP_RD_ARRAY;
					else if (cmd_data == FCP_CMD_READ_STATUS)
						s_d.rdmode = FCP_RD_STATUS;
					else if (cmd_data == FCP_CMD_READ_ID)
						s_d.rdmode = FCP_RD_ID;
				end
				default:
					s_d.st = ST_IDLE;
			endcase
		end

		if (go)
		begin
			s_d.pin_top_lk  = pin_top_now;
			s_d.pin_rest_lk = pin_rest_now;
			s_d.rdmode      = FCP_RD_STATUS;
			fail_lock = fcp_blocked(s_d.op_erase ? op_blk : cmd_blk, s_q, pin_top_now, pin_rest_now);
			if (fail_lock || supply_low)
			begin
				s_d.status[FCP_SR_PROTECT] = fail_lock;
				s_d.status[FCP_SR_SUPPLY]  = supply_low;
				if (s_d.op_erase)
					s_d.status[FCP_SR_ERASE_ERR] = 1'b1;
				else
					s_d.status[FCP_SR_PROG_ERR] = 1'b1;
			end
			else
			begin
				start_op = 1'b1;
				s_d.st   = ST_RUN;
			end
		end

		if (arr.done)
		begin
			s_d.st = ST_IDLE;
			if (s_q.op_erase)
			begin
				for (int i = 0; i < BLOCK_BYTES; i++)
					s_d.mem[{op_blk, OW'(i)}] = FCP_ERASED_BYTE;
				s_d.status[FCP_SR_ERASE_ERR] = 1'b0;
			end
			else
			begin
				s_d.mem[s_q.op_addr] = s_q.mem[s_q.op_addr] & s_q.op_data;
				s_d.status[FCP_SR_PROG_ERR] = 1'b0;
			end
		end

		s_d.status[FCP_SR_READY]     = !(s_d.st == ST_RUN);
		s_d.status[FCP_SR_ERASE_SUS] = (s_d.st == ST_SUSPEND) && s_d.op_erase;
		s_d.status[FCP_SR_PROG_SUS]  = (s_d.st == ST_SUSPEND) && !s_d.op_erase;
		s_d.status[0]                = 1'b0;

		if (cmd_read)
		begin
			unique case (s_q.rdmode)
				FCP_RD_STATUS:
					s_d.rdata = s_q.status;
				FCP_RD_ID:
					s_d.rdata = cmd_addr[0] ? FCP_ID_DEVICE : FCP_ID_MAKER;
				default:
					s_d.rdata = s_q.rlock[cmd_blk] ? 8'h00 : s_q.mem[cmd_addr];
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// State register
	always_ff @(posedge clk or posedge reset)
	begin
		if (reset)
		begin
			s_q        <= '0;
			s_q.st     <= ST_IDLE;
			s_q.rdmode <= FCP_RD_ARRAY;
			s_q.wlock  <= '1;
			s_q.status <= 8'h80;
			s_q.tbl_sync <= 2'b11;
			s_q.wp_sync  <= 2'b11;
			s_q.mem    <= '1;
		end
		else
			s_q <= s_d;
	end

	assign read_data        = s_q.rdata;
	assign write_lock_state = s_q.wlock;
	assign ready_flag       = s_q.status[FCP_SR_READY];
endmodule : fcp_flash_command_protect

// ---- dv/fcp_flash_command_protect_chk.sv ----
/*
 Port-level checks on the flash command and protect block.
 Assumes 2-flop pin synchronisers and a short operation count in simulation.
*/
module fcp_flash_command_protect_chk
#(
	parameter int BLOCKS      = 4,
	parameter int BLOCK_BYTES = 4,
	parameter int OP_CYCLES   = 4
)
(
	input wire logic                                  clk,
	input wire logic                                  reset,
	input wire logic                                  cmd_write,
	input wire logic [$clog2(BLOCKS*BLOCK_BYTES)-1:0] cmd_addr,
	input wire logic [7:0]                            cmd_data,
	input wire logic                                  cmd_read,
	input wire logic [7:0]                            read_data,
	input wire logic                                  lock_write,
	input wire logic [$clog2(BLOCKS)-1:0]             lock_block,
	input wire logic                                  lock_wr_bit,
	input wire logic [BLOCKS-1:0]                     write_lock_state,
	input wire logic                                  top_block_lock_pin_n,
	input wire logic                                  write_protect_pin_n,
	input wire logic                                  supply_lockout_level,
	input wire logic                                  ready_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MAXW = 40;
	logic top_hit;
	assign top_hit = (cmd_addr / BLOCK_BYTES) == (BLOCKS - 1);
	default clocking cb @(posedge clk); endclocking
	default disable iff (reset);
	////////////////////////////////////////////////////////////////
	a_reset_state: assert property (disable iff (1'b0)
		reset && $past(reset) |-> ready_flag && write_lock_state == '1 && read_data == 8'h00)
		else $error("reset state wrong");
	a_lock_update: assert property (
		lock_write |=> write_lock_state[$past(lock_block)] == $past(lock_wr_bit)) else $error("lock bit not written");
	a_lock_hold: assert property (!lock_write |=> $stable(write_lock_state))
		else $error("lock bits moved");
	a_read_hold: assert property (!cmd_read |=> $stable(read_data))
		else $error("read data moved");
	a_ready_idle: assert property (
		ready_flag && !cmd_write && !$past(cmd_write) && !$past(cmd_write, 2) |=> ready_flag) else $error("busy without cause");
	a_busy_bound: assert property ($fell(ready_flag) |-> ##[1:MAXW] ready_flag)
		else $error("operation never ends");
	a_top_pin_block: assert property (
		(!top_block_lock_pin_n) [*3] ##0 (ready_flag && cmd_write && top_hit && cmd_data != 8'hd0)
		|=> ready_flag [*3]) else $error("top block write not refused");
	a_wp_pin_block: assert property (
		(!write_protect_pin_n) [*3] ##0 (ready_flag && cmd_write && !top_hit && cmd_data != 8'hd0)
		|=> ready_flag [*3]) else $error("block write not refused");
	a_supply_block: assert property (
		supply_lockout_level [*3] ##0 (ready_flag && cmd_write && cmd_data != 8'hd0)
		|=> ready_flag [*3]) else $error("write under supply lockout");
	c_op_run: cover property ($fell(ready_flag));
	c_unlock: cover property (lock_write && !lock_wr_bit);
	c_top_try: cover property ((!top_block_lock_pin_n) [*3] ##0 (cmd_write && top_hit));
endmodule : fcp_flash_command_protect_chk

bind fcp_flash_command_protect fcp_flash_command_protect_chk #(
	.BLOCKS(BLOCKS), .BLOCK_BYTES(BLOCK_BYTES), .OP_CYCLES(OP_CYCLES)
) fcp_flash_command_protect_chk_inst (
	.clk, .reset, .cmd_write, .cmd_addr, .cmd_data, .cmd_read, .read_data, .lock_write, .lock_block,
	.lock_wr_bit, .write_lock_state, .top_block_lock_pin_n, .write_protect_pin_n, .supply_lockout_level, .ready_flag
);

// ---- dv/fcp_host_model.sv ----
/*
 Host model: issues command writes and reads on the command port.
 Assumes the bench makes one request at a time.
*/
module fcp_host_model
(
	input  wire logic       clk,
	output logic            cmd_write,
	output logic            cmd_read,
	output logic      [3:0] cmd_addr,
	output logic      [7:0] cmd_data,
	input  wire logic [7:0] read_data
);
	timeunit 1ns;
	timeprecision 1ps;
	initial
	begin
		cmd_write = 1'b0;
		cmd_read = 1'b0;
		cmd_addr = 4'h0;
		cmd_data = 8'h00;
	end
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(posedge clk);
		cmd_write <= 1'b1;
		cmd_addr <= a;
		cmd_data <= v;
		@(posedge clk);
		cmd_write <= 1'b0;
		cmd_addr <= ~a;
		cmd_data <= ~v;
	endtask : wr
	task automatic rd(input logic [3:0] a, output logic [7:0] v);
		@(posedge clk);
		cmd_read <= 1'b1;
		cmd_addr <= a;
		@(posedge clk);
		cmd_read <= 1'b0;
		cmd_addr <= ~a;
		#1 v = read_data;
	endtask : rd
endmodule : fcp_host_model

// ---- dv/tb_flash_command_protect.sv ----
/*
 Bench: host command sequences with expected read-back.
 Assumes the host model and the bound checker are compiled first.
*/
module tb_flash_command_protect;
	timeunit 1ns;
	timeprecision 1ps;
	logic       clk, reset, cmd_write, cmd_read, lock_write, lock_wr_bit, lock_rd_bit, ready_flag;
	logic       top_block_lock_pin_n, write_protect_pin_n, supply_lockout_level;
	logic [3:0] cmd_addr, write_lock_state;
	logic [1:0] lock_block;
	logic [7:0] cmd_data, read_data, d;
	int         num_errors, tests_run;
	fcp_host_model fcp_host_model_inst (.clk, .cmd_write, .cmd_read, .cmd_addr, .cmd_data, .read_data);
	fcp_flash_command_protect #(.OP_CYCLES(4)) fcp_flash_command_protect_inst (.clk, .reset, .cmd_write,
		.cmd_addr, .cmd_data, .cmd_read, .read_data, .lock_write, .lock_block, .lock_wr_bit, .lock_rd_bit,
		.write_lock_state, .top_block_lock_pin_n, .write_protect_pin_n, .supply_lockout_level, .ready_flag);
	////////////////////////////////////////////////////////////////
	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		fcp_host_model_inst.wr(a, v);
	endtask : wr
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		tests_run++;
		if (got !== exp)
		begin
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
			num_errors++;
		end
	endtask : chk
	task automatic rdc(input logic [3:0] a, input logic [7:0] exp);
		fcp_host_model_inst.rd(a, d);
		chk(d, exp);
	endtask : rdc
	task automatic st(input logic [7:0] exp);
		wr(4'h0, 8'h70);
		rdc(4'h0, exp);
		wr(4'h0, 8'h50);
	endtask : st
	task automatic ar(input logic [3:0] a, input logic [7:0] exp);
		wr(a, 8'hff);
		rdc(a, exp);
	endtask : ar
	task automatic wt;
		repeat (3) @(posedge clk);
		@(negedge clk);
		for (int i = 0; i < 40 && ready_flag !== 1'b1; i++) @(negedge clk);
		chk({7'h00, ready_flag}, 8'h01);
	endtask : wt
	task automatic op(input logic [7:0] c, input logic [3:0] a, input logic [7:0] v);
		wr(a, c);
		wr(a, v);
		wt();
	endtask : op
	task automatic lk(input logic [1:0] b, input logic w, input logic r);
		@(posedge clk);
		lock_write <= 1'b1;
		lock_block <= b;
		lock_wr_bit <= w;
		lock_rd_bit <= r;
		@(posedge clk);
		lock_write <= 1'b0;
		@(negedge clk);
	endtask : lk
	task automatic pins(input logic t, input logic w, input logic s);
		@(posedge clk);
		top_block_lock_pin_n <= t;
		write_protect_pin_n <= w;
		supply_lockout_level <= s;
		repeat (4) @(posedge clk);
	endtask : pins
	task automatic end_of_test;
		$display("tests %0d errors %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : end_of_test
	////////////////////////////////////////////////////////////////
	initial
	begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	initial
	begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_of_test();
	end
	initial
	begin
		reset = 1'b1;
		lock_write = 1'b0;
		lock_block = 2'h0;
		lock_wr_bit = 1'b0;
		lock_rd_bit = 1'b0;
		top_block_lock_pin_n = 1'b1;
		write_protect_pin_n = 1'b1;
		supply_lockout_level = 1'b0;
		num_errors = 0;
		tests_run = 0;
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		pins(1'b1, 1'b1, 1'b0);
		chk({3'h0, ready_flag, write_lock_state}, 8'h1f);
		op(8'h40, 4'h1, 8'h00);
		st(8'h92);
		st(8'h80);
		for (int b = 0; b < 4; b++) lk(b[1:0], 1'b0, 1'b0);
		chk({4'h0, write_lock_state}, 8'h00);
		op(8'h40, 4'h1, 8'h12);
		st(8'h80);
		op(8'h10, 4'h5, 8'h34);
		ar(4'h1, 8'h12);
		op(8'h20, 4'h0, 8'hd0);
		st(8'h80);
		ar(4'h1, 8'hff);
		ar(4'h5, 8'h34);
		wr(4'h0, 8'h20);
		wr(4'h4, 8'hd0);
		st(8'hb0);
		pins(1'b0, 1'b1, 1'b0);
		op(8'h40, 4'hc, 8'h00);
		st(8'h92);
		op(8'h40, 4'h8, 8'h0f);
		ar(4'h8, 8'h0f);
		pins(1'b1, 1'b0, 1'b0);
		op(8'h40, 4'hc, 8'h5a);
		ar(4'hc, 8'h5a);
		op(8'h40, 4'h9, 8'h00);
		st(8'h92);
		lk(2'h2, 1'b0, 1'b1);
		ar(4'h8, 8'h00);
		lk(2'h2, 1'b0, 1'b0);
		pins(1'b1, 1'b1, 1'b1);
		op(8'h40, 4'h6, 8'h00);
		st(8'h98);
		ar(4'h5, 8'h34);
		wr(4'h0, 8'h90);
		rdc(4'h0, 8'h5a);
		rdc(4'h1, 8'h3c);
		pins(1'b1, 1'b1, 1'b0);
		wr(4'h4, 8'h20);
		wr(4'h4, 8'hd0);
		wr(4'h0, 8'hb0);
		wt();
		wr(4'h0, 8'h70);
		rdc(4'h0, 8'hc0);
		pins(1'b1, 1'b0, 1'b0);
		wr(4'h0, 8'hd0);
		wt();
		st(8'h80);
		ar(4'h5, 8'hff);
		end_of_test();
	end
endmodule : tb_flash_command_protect
